// File: bsc_clk_div.sv
// conversion clock divider: one-cycle tick every divider+1 cycles
// assumes divider is stable while run is high
`timescale 1ns/100ps
module bsc_clk_div (
    input  wire logic ref_clk_i,
    input  wire logic sys_rst_i,
    bsc_clk_if.div    clk_if
);
    import bsc_pkg::*;
    logic [DIV_W-1:0] cnt_ff;
    wire              wrap = (cnt_ff == clk_if.divider);

    // sysclk divided by divider plus one
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i || !clk_if.run || wrap) begin
            cnt_ff <= '0;
        end else begin
            cnt_ff <= cnt_ff + 5'h01;
        end
    end
    assign clk_if.tick = clk_if.run && wrap;
endmodule

// File: bsc_clk_if.sv
// interface between the control core and the conversion clock divider
// assumes both ends run on the same system clock
`timescale 1ns/100ps
interface bsc_clk_if;
    import bsc_pkg::*;
    logic [DIV_W-1:0] divider;
    logic             run;
    logic             tick;
    modport ctrl (output divider, output run, input tick);
    modport div  (input divider, input run, output tick);
endinterface

// File: bsc_ctrl.sv
// conversion control core of the byte converter
// assumes timer overflows are one-cycle pulses on ref_clk_i,
// external start and comparator come from pins
`timescale 1ns/100ps
module bsc_ctrl (
    input  wire logic                        ref_clk_i,
    input  wire logic                        sys_rst_i,
    input  wire logic                        converter_enable_bit_i,
    input  wire logic                        track_mode_bit_i,
    input  wire logic                        chip_standby_i,
    input  wire bsc_pkg::bsc_src_t           start_source_field_i,
    input  wire logic [bsc_pkg::DIV_W-1:0]   sar_clock_divider_i,
    input  wire logic [bsc_pkg::GAIN_W-1:0]  gain_select_field_i,
    input  wire logic                        gain_wr_i,
    input  wire logic [bsc_pkg::CH_W-1:0]    channel_select_i,
    input  wire logic                        channel_wr_i,
    input  wire logic                        busy_wr_one_i,
    input  wire logic                        companion_busy_wr_one_i,
    input  wire logic                        timer3_ovf_i,
    input  wire logic                        timer2_ovf_i,
    input  wire logic                        external_convert_start_i,
    input  wire logic                        comparator_i,
    input  wire logic                        done_flag_clr_i,
    input  wire logic                        interrupt_enable_i,
    output logic                             analog_power_o,
    output logic                             track_o,
    output logic [bsc_pkg::CH_W-1:0]         channel_o,
    output logic [bsc_pkg::GAIN_W-1:0]       gain_o,
    output logic [bsc_pkg::DATA_W-1:0]       trial_code_o,
    output logic                             conversion_busy_bit_o,
    output logic                             conversion_done_flag_o,
    output logic                             converter_irq_o,
    output logic                             companion_start_o,
    output logic [bsc_pkg::DATA_W-1:0]       result_o
);
    import bsc_pkg::*;

    bsc_clk_if clk_if ();

    bsc_state_t       state_ff;
    bsc_state_t       nxt_state;
    logic             ext_meta_ff;
    logic             ext_sync_ff;
    logic             ext_prev_ff;
    logic             cmp_meta_ff;
    logic             cmp_sync_ff;
    logic [1:0]       trk_cnt_ff;
    logic [2:0]       bit_ff;
    logic [DATA_W-1:0] sar_ff;
    logic [DATA_W-1:0] result_ff;
    logic             done_ff;
    logic             busy_prev_ff;
    logic [GAIN_W-1:0] gain_ff;
    logic [CH_W-1:0]  chan_ff;
    logic             ext_wait_ff;
    logic [6:0]       gap_ff;

    // pins pass two flip-flops before use
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            // high so an idle-high pin gives no false edge
            ext_meta_ff <= 1'b1;
            ext_sync_ff <= 1'b1;
            ext_prev_ff <= 1'b1;
            cmp_meta_ff <= 1'b0;
            cmp_sync_ff <= 1'b0;
        end else begin
            ext_meta_ff <= external_convert_start_i;
            ext_sync_ff <= ext_meta_ff;
            ext_prev_ff <= ext_sync_ff;
            cmp_meta_ff <= comparator_i;
            cmp_sync_ff <= cmp_meta_ff;
        end
    end

    wire enabled  = converter_enable_bit_i;
    wire ext_rise = ext_sync_ff && !ext_prev_ff;
    wire busy     = (state_ff != BSC_IDLE);
    wire rate_ok  = (gap_ff == GAP_RST);

    // one source at a time
    wire src_sw   = (start_source_field_i == BSC_SRC_SW)
                    && busy_wr_one_i;
    wire src_t3   = (start_source_field_i == BSC_SRC_TMR3)
                    && timer3_ovf_i;
    wire src_ext  = (start_source_field_i == BSC_SRC_EXT)
                    && ext_rise;
    wire src_t2   = (start_source_field_i == BSC_SRC_TMR2)
                    && timer2_ovf_i;
    wire src_shr  = (start_source_field_i == BSC_SRC_SHARED)
                    && companion_busy_wr_one_i;
    wire start_req = src_sw || src_t3 || src_ext || src_t2 || src_shr;

    // ignored while busy or above max rate
    wire start_ok = enabled && !busy && rate_ok && start_req;

    // external start in low-power mode: track while low
    wire ext_lp   = track_mode_bit_i
                    && (start_source_field_i == BSC_SRC_EXT);
    wire lp_track = track_mode_bit_i && !ext_lp;

    wire tick     = clk_if.tick;
    wire trk_done = tick && (trk_cnt_ff == 2'(LP_TRACK_CLKS - 1));
    wire conv_end = tick && (bit_ff == 3'h0) && (state_ff == BSC_CONV);

    assign clk_if.divider = sar_clock_divider_i;
    assign clk_if.run     = busy;

    bsc_clk_div u_div (
        .ref_clk_i (ref_clk_i),
        .sys_rst_i (sys_rst_i),
        .clk_if    (clk_if.div)
    );

    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            BSC_IDLE: begin
                if (start_ok) begin
                    nxt_state = lp_track ? BSC_TRACK : BSC_CONV;
                end
            end
            BSC_TRACK: begin
                if (trk_done) begin
                    nxt_state = BSC_CONV;
                end
            end
            BSC_CONV: begin
                if (conv_end) begin
                    nxt_state = BSC_IDLE;
                end
            end
            default: nxt_state = BSC_IDLE;
        endcase
        if (!enabled) begin
            nxt_state = BSC_IDLE;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            state_ff <= BSC_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // low-power tracking interval counter
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i || state_ff != BSC_TRACK) begin
            trk_cnt_ff <= 2'h0;
        end else if (tick) begin
            trk_cnt_ff <= trk_cnt_ff + 2'h1;
        end
    end

    // msb-first successive approximation
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            bit_ff <= 3'h7;
            sar_ff <= 8'h80;
        end else if (state_ff != BSC_CONV) begin
            bit_ff <= 3'h7;
            sar_ff <= 8'h80;
        end else if (tick) begin
            bit_ff <= bit_ff - 3'h1;
            sar_ff <= sar_step(sar_ff, bit_ff, cmp_sync_ff);
        end
    end

    function automatic logic [DATA_W-1:0] sar_step(
        input logic [DATA_W-1:0] code,
        input logic [2:0]        pos,
        input logic              keep
    );
        logic [DATA_W-1:0] nxt;
        nxt = code;
        nxt[pos] = keep;
        if (pos != 3'h0) begin
            nxt[pos - 3'h1] = 1'b1;
        end
        return nxt;
    endfunction

    // result capture
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            result_ff <= '0;
        end else if (conv_end) begin
            result_ff <= sar_step(sar_ff, bit_ff, cmp_sync_ff);
        end
    end

    // done flag on busy falling edge, set wins
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            busy_prev_ff <= 1'b0;
            done_ff      <= 1'b0;
        end else begin
            busy_prev_ff <= busy;
            if (busy_prev_ff && !busy) begin
                done_ff <= 1'b1;
            end else if (done_flag_clr_i) begin
                done_ff <= 1'b0;
            end
        end
    end

    // min start spacing for the 500 ksps limit
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            gap_ff <= GAP_RST;
        end else if (start_ok) begin
            gap_ff <= 7'(MIN_START_CYC - 1);
        end else if (gap_ff != GAP_RST) begin
            gap_ff <= gap_ff - 7'h01;
        end
    end

    // gain and channel configuration
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            gain_ff <= GAIN_RST;
            chan_ff <= CH_RST;
        end else begin
            if (gain_wr_i) begin
                gain_ff <= gain_select_field_i;
            end
            if (channel_wr_i) begin
                chan_ff <= channel_select_i;
            end
        end
    end

    // external low-power: arm tracking window on low level
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            ext_wait_ff <= 1'b0;
        end else begin
            ext_wait_ff <= ext_lp && !ext_sync_ff;
        end
    end

    // track: default continuous, lp only in window
    wire trk_default = !track_mode_bit_i && !busy;
    wire trk_lp      = lp_track && (state_ff == BSC_TRACK);
    wire trk_ext     = ext_wait_ff && !busy;

    always_comb begin
        track_o = enabled && !chip_standby_i
                  && (trk_default || trk_lp || trk_ext);
    end

    assign analog_power_o         = enabled;
    assign channel_o              = chan_ff;
    assign gain_o                 = gain_ff;
    assign trial_code_o           = sar_ff;
    assign conversion_busy_bit_o  = busy;
    assign conversion_done_flag_o = done_ff;
    assign converter_irq_o        = done_ff && interrupt_enable_i;
    assign companion_start_o      = src_shr && start_ok;
    assign result_o               = result_ff;
endmodule

// File: bsc_ctrl_asserts.sv
// port assertions for the conversion control core
// assumes one clock domain with synchronous active-high reset
`timescale 1ns/100ps
module bsc_ctrl_asserts (
    input wire logic                      ref_clk_i,
    input wire logic                      sys_rst_i,
    input wire logic                      converter_enable_bit_i,
    input wire logic                      chip_standby_i,
    input wire logic                      interrupt_enable_i,
    input wire logic                      analog_power_o,
    input wire logic                      track_o,
    input wire logic                      conversion_busy_bit_o,
    input wire logic                      conversion_done_flag_o,
    input wire logic                      converter_irq_o,
    input wire logic [bsc_pkg::DATA_W-1:0] result_o
);
    import bsc_pkg::*;
    wire busy = conversion_busy_bit_o;
    wire flag = conversion_done_flag_o;
    wire en   = converter_enable_bit_i;
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);
    sequence s_begin;
        $rose(busy);
    endsequence
    sequence s_end;
        $fell(busy);
    endsequence
    a_power_follows:
        assert property (analog_power_o == en) else $error("bad power");
    a_off_idle:
        assert property (!en |=> !busy) else $error("busy while off");
    a_busy_spans:
        assert property (s_begin |-> (busy || !en) [*8])
        else $error("busy too short");
    a_busy_ends:
        assert property (s_begin |-> ##[8:400] !busy)
        else $error("busy too long");
    a_flag_on_fall:
        assert property (s_end |=> flag) else $error("flag not set");
    a_irq_gate:
        assert property (converter_irq_o == (flag && interrupt_enable_i))
        else $error("bad irq");
    a_result_when:
        assert property ($changed(result_o) |-> s_end)
        else $error("result moved");
    a_standby_stops:
        assert property (chip_standby_i |-> !track_o)
        else $error("track in standby");
endmodule
bind bsc_ctrl bsc_ctrl_asserts u_chk (.ref_clk_i, .sys_rst_i,
    .converter_enable_bit_i, .chip_standby_i, .interrupt_enable_i,
    .analog_power_o, .track_o, .conversion_busy_bit_o,
    .conversion_done_flag_o, .converter_irq_o, .result_o);

// File: bsc_ctrl_tb.sv
// self-checking bench for the conversion control core
// assumes the port checker is bound to the core
`timescale 1ns/100ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
    failures++; $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module bsc_ctrl_tb;
    import bsc_pkg::*;
    logic clk = 0, rst = 1, en = 1, tm = 0, sb = 0, gwr = 0, cwr = 0;
    logic bwr = 0, cbw = 0, t3 = 0, t2 = 0, cmp = 1, clr = 0, ie = 1;
    logic go = 0, ext, pwr, trk, busy, flag, irq, cst;
    bsc_src_t   src = BSC_SRC_SW;
    logic [4:0] div = 5'h08;
    logic [1:0] gs = 2'h0, gn;
    logic [2:0] cs = 3'h0, ch;
    logic [7:0] trial, res, last;
    int failures = 0, total_checks = 0, cycles = 0, cst_n = 0;
    bsc_ext_src i_src (.ref_clk_i(clk), .go_i(go), .low_cyc_i(8'h14),
        .pin_o(ext));
    bsc_ctrl i_dut (.ref_clk_i(clk), .sys_rst_i(rst),
        .converter_enable_bit_i(en), .track_mode_bit_i(tm),
        .chip_standby_i(sb), .start_source_field_i(src),
        .sar_clock_divider_i(div), .gain_select_field_i(gs),
        .gain_wr_i(gwr), .channel_select_i(cs), .channel_wr_i(cwr),
        .busy_wr_one_i(bwr), .companion_busy_wr_one_i(cbw),
        .timer3_ovf_i(t3), .timer2_ovf_i(t2), .comparator_i(cmp),
        .external_convert_start_i(ext), .done_flag_clr_i(clr),
        .interrupt_enable_i(ie), .analog_power_o(pwr), .track_o(trk),
        .channel_o(ch), .gain_o(gn), .trial_code_o(trial),
        .conversion_busy_bit_o(busy), .conversion_done_flag_o(flag),
        .converter_irq_o(irq), .companion_start_o(cst), .result_o(res));
    always #10 clk = ~clk;
    // tests need about 3000 cycles
    always @(posedge clk) begin
        cycles++;
        if (cst === 1'b1)
            cst_n++;
        if (cycles == 20000) begin
            failures++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        cyc(1);
        s = 1'b0;
    endtask
    // clear flag, start, count busy cycles, leave start spacing
    task automatic run(output int n);
        n = 0;
        pulse(clr);
        case (src)
            BSC_SRC_SW:     pulse(bwr);
            BSC_SRC_TMR3:   pulse(t3);
            BSC_SRC_EXT:    pulse(go);
            BSC_SRC_TMR2:   pulse(t2);
            BSC_SRC_SHARED: pulse(cbw);
            default:        pulse(bwr);
        endcase
        repeat (60) if (!busy) cyc(1);
        while (busy === 1'b1 && n < 600) begin
            n++;
            cyc(1);
        end
        cyc(110);
    endtask
    task automatic t_idle;
        `CHK("gain", 2'h0, gn)
        `CHK("trial", 8'h80, trial)
        `CHK("track", 1'b1, trk)
        for (int i = 0; i < 8; i++) begin
            gs = i[1:0];
            cs = i[2:0];
            gwr = 1'b1;
            cwr = 1'b1;
            cyc(1);
            gwr = 1'b0;
            cwr = 1'b0;
            `CHK("gain", i[1:0], gn)
            `CHK("channel", i[2:0], ch)
        end
        sb = 1'b1;
        cyc(1);
        `CHK("standby", 1'b0, trk)
        sb = 1'b0;
        $display("t_idle done");
    endtask
    task automatic t_src;
        int n;
        for (int s = 0; s < 6; s++) begin
            src = bsc_src_t'(s[2:0]);
            cst_n = 0;
            run(n);
            `CHK("started", s < 5, n > 0)
            `CHK("irq", s < 5, irq)
            `CHK("companion", s == 4, cst_n == 1)
            `CHK("result", 8'hff, res)
        end
        cmp = 1'b0;
        src = BSC_SRC_SW;
        run(n);
        `CHK("zero code", 8'h00, res)
        cmp = 1'b1;
        $display("t_src done");
    endtask
    task automatic t_timing;
        int a, b, c;
        run(a);
        div = 5'h09;
        run(b);
        tm = 1'b1;
        run(c);
        tm = 1'b0;
        `CHK("div step", 8, b - a)
        `CHK("lp track", 30, c - b)
        $display("t_timing done");
    endtask
    task automatic t_abort;
        div = 5'h1f;
        pulse(clr);
        pulse(bwr);
        cyc(20);
        last = res;
        en = 1'b0;
        ie = 1'b0;
        cyc(2);
        `CHK("abort busy", 1'b0, busy)
        `CHK("power", 1'b0, pwr)
        `CHK("abort flag", 1'b1, flag)
        `CHK("kept result", last, res)
        en = 1'b1;
        ie = 1'b1;
        pulse(bwr);
        `CHK("early start", 1'b0, busy)
        cyc(110);
        pulse(bwr);
        cyc(100);
        pulse(bwr);
        `CHK("busy kept", 1'b1, busy)
        en = 1'b0;
        cyc(1);
        en = 1'b1;
        pulse(bwr);
        `CHK("late start", 1'b1, busy)
        repeat (300) if (busy) cyc(1);
        cyc(110);
        div = 5'h08;
        $display("t_abort done");
    endtask
    task automatic t_ext;
        src = BSC_SRC_EXT;
        tm = 1'b1;
        cyc(5);
        `CHK("idle track", 1'b0, trk)
        pulse(go);
        cyc(10);
        `CHK("window track", 1'b1, trk)
        repeat (40) if (!busy) cyc(1);
        `CHK("ext start", 1'b1, busy)
        repeat (300) if (busy) cyc(1);
        tm = 1'b0;
        $display("t_ext done");
    endtask
    initial begin
        cyc(20);
        rst = 1'b0;
        cyc(1);
        t_idle;
        t_src;
        t_timing;
        t_abort;
        t_ext;
        tally_and_finish();
    end
endmodule

// File: bsc_ext_src.sv
// board source of the external convert-start pin
// assumes go_i is a one-cycle request from the bench
`timescale 1ns/100ps
module bsc_ext_src (
    input  wire logic       ref_clk_i,
    input  wire logic       go_i,
    input  wire logic [7:0] low_cyc_i,
    output logic            pin_o
);
    logic [7:0] cnt_ff = 8'h00;
    initial pin_o = 1'b1;
    // low window is the tracking time
    always @(posedge ref_clk_i) begin
        if (go_i) begin
            pin_o  <= 1'b0;
            cnt_ff <= low_cyc_i;
        end else if (cnt_ff != 8'h00) begin
            cnt_ff <= cnt_ff - 8'h01;
            pin_o  <= (cnt_ff == 8'h01);
        end
    end
endmodule

// File: bsc_pkg.sv
// package of constants for the byte converter conversion control
// assumes a single 50 MHz system clock and plain control ports
package bsc_pkg;
    localparam int SYS_CLK_HZ      = 50000000;
    localparam int MAX_RATE_SPS    = 500000;
    // least system cycles between starts for 500 ksps
    localparam int MIN_START_CYC   = (SYS_CLK_HZ + MAX_RATE_SPS - 1)
                                     / MAX_RATE_SPS;
    localparam int DIV_W           = 5;
    localparam int DATA_W          = 8;
    localparam int CH_W            = 3;
    localparam int GAIN_W          = 2;
    localparam int LP_TRACK_CLKS   = 3;
    localparam logic [DIV_W-1:0]  DIV_RST  = 5'h1f;
    localparam logic [GAIN_W-1:0] GAIN_RST = 2'h0;
    localparam logic [CH_W-1:0]   CH_RST   = 3'h0;
    localparam logic [6:0]        GAP_RST  = 7'h00;

    typedef enum logic [2:0] {
        BSC_SRC_SW     = 3'h0,
        BSC_SRC_TMR3   = 3'h1,
        BSC_SRC_EXT    = 3'h2,
        BSC_SRC_TMR2   = 3'h3,
        BSC_SRC_SHARED = 3'h4
    } bsc_src_t;

    typedef enum logic [1:0] {
        BSC_IDLE  = 2'h0,
        BSC_TRACK = 2'h1,
        BSC_CONV  = 2'h2
    } bsc_state_t;
endpackage
